/* verif/emc_ctrl_assertions.sv */
`timescale 1ns/1ns
module emc_ctrl_assertions #(
  parameter AW = 16,
  parameter DW = 8
) (
  // clock and reset
  input wire          pclk,
  input wire          presetn,
  // core side
  input wire          cpu_req,
  input wire          cpu_wr,
  input wire [AW-1:0] cpu_addr,
  input wire [DW-1:0] cpu_wdata,
  input wire          cpu_ack,
  input wire [DW-1:0] cpu_rdata,
  input wire          cpu_blocked,
  // pins
  input wire [7:0]    gp_p1_oe,
  input wire [7:0]    p0_o,
  input wire [7:0]    p0_oe,
  input wire [7:0]    p1_o,
  input wire [7:0]    p1_oe,
  input wire [7:0]    p3_o,
  input wire [7:0]    p3_oe,
  input wire          ext_irq_zero,
  input wire          port1_bit1_is_wait
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pin levels only count while the bus drives the pin
  wire rd_low = p1_oe[6] & ~p1_o[6];
  wire wr_low = p1_oe[5] & ~p1_o[5];
  wire ale_on = p1_oe[7] & p1_o[7];
  // latch strobe is one cycle high, then low while the address is held
  sequence s_ale_pulse;
    ale_on ##1 !ale_on;
  endsequence
  a_rd_only_read: assert property (rd_low |-> cpu_req && !cpu_wr)
    else $error("read strobe low outside a read");
  a_wr_only_write: assert property (wr_low |-> cpu_req && cpu_wr)
    else $error("store strobe low outside a write");
  a_ale_opens_cycle: assert property ($rose(ale_on) |-> s_ale_pulse ##[2:60] cpu_ack)
    else $error("latch strobe not followed by an ack");
  a_addr_latched: assert property ($fell(ale_on) |-> p0_oe == 8'hFF && p0_o == cpu_addr[7:0])
    else $error("low address not held at latch edge");
  a_upper_addr: assert property ($rose(ale_on) |-> (p3_o & p3_oe) == (cpu_addr[AW-1:AW-8] & p3_oe))
    else $error("upper address pins wrong");
  a_rd_bus_free: assert property (rd_low |-> p0_oe == 8'h00)
    else $error("data pins driven during read");
  a_wr_data_out: assert property (wr_low |-> p0_oe == 8'hFF && p0_o == cpu_wdata)
    else $error("store data not on data pins");
  a_wait_pin_in: assert property (port1_bit1_is_wait |-> !p1_oe[1])
    else $error("wait pin driven");
  a_irq_gated: assert property (p1_oe[7] && !gp_p1_oe[7] |-> !ext_irq_zero)
    else $error("interrupt input live with bus on");
  a_blocked_zero: assert property (cpu_blocked |-> cpu_ack && cpu_rdata == 8'h00)
    else $error("blocked read returned data");
endmodule // emc_ctrl_assertions

bind emc_ctrl emc_ctrl_assertions #(.AW(AW), .DW(DW)) u_emc_ctrl_assertions (
  .pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
  .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_blocked(cpu_blocked),
  .gp_p1_oe(gp_p1_oe), .p0_o(p0_o), .p0_oe(p0_oe), .p1_o(p1_o), .p1_oe(p1_oe), .p3_o(p3_o),
  .p3_oe(p3_oe), .ext_irq_zero(ext_irq_zero), .port1_bit1_is_wait(port1_bit1_is_wait)
);

/* verif/emc_mem_model.sv */
`timescale 1ns/1ns
module emc_mem_model #(
  parameter WAIT_N = 3
) (
  // clock and bus pins seen from the far side
  input  wire       pclk,
  input  wire [7:0] p0_o,
  input  wire [7:0] p0_oe,
  input  wire [7:0] p1_o,
  input  wire [7:0] p1_oe,
  input  wire [7:0] p3_o,
  // wait request control and answers
  input  wire       stall_en,
  output wire [7:0] p0_i,
  output wire       wait_n
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_r;
  logic [7:0] cnt = 8'h00;
  logic [7:0] tog_r = 8'h00;
  wire        rd_low = p1_oe[6] & ~p1_o[6];
  wire        wr_low = p1_oe[5] & ~p1_o[5];
  // address latch closes on the falling latch strobe
  always @(negedge p1_o[7])
    lat_r <= p0_o;
  // store while the store strobe is low; count strobe cycles for the stall
  always @(posedge pclk)
  begin
    if (wr_low)
      mem[{p3_o, lat_r}] <= p0_o;
    cnt <= (rd_low | wr_low) ? cnt + 8'h01 : 8'h00;
    tog_r <= ~tog_r;
  end
  // a released data bus shows a changing pattern, never the last value
  assign p0_i = rd_low ? mem[{p3_o, lat_r}] : (p0_o & p0_oe) | (tog_r & ~p0_oe);
  // wait pin has a pull-up; held low for a fixed stall when asked
  assign wait_n = ~(stall_en & (rd_low | wr_low) & (cnt < WAIT_N));
endmodule // emc_mem_model

/* verif/ext_memory_bus_control_tb.sv */
`timescale 1ns/1ns
module ext_memory_bus_control_tb;
  // bench-driven inputs
  logic        pclk, presetn, psel, penable, pwrite, boot, cpu_req, cpu_wr, cpu_ce, irq_pin, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata, gp0, gp1, gp3, rnd;
  // design and memory model outputs
  wire  [31:0] prdata;
  wire         pready, pslverr, cpu_ack, cpu_ext, cpu_blocked, irq0, is_wait, wait_n;
  wire  [7:0]  cpu_rdata, p0_i, p0_o, p0_oe, p1_o, p1_oe, p3_o, p3_oe;
  // scoreboard
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [5:0]  lat;
  int          num_errors = 0;
  int          total_checks = 0;

  emc_ctrl u_emc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_source_pin(boot),
    .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_code_ext(cpu_ce), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_ext(cpu_ext), .cpu_blocked(cpu_blocked), .cpu_region(),
    .gp_p0_o(gp0), .gp_p0_oe(8'h00), .gp_p1_o(gp1), .gp_p1_oe(8'h00), .gp_p3_o(gp3), .gp_p3_oe(8'h00),
    .p0_i(p0_i), .p0_o(p0_o), .p0_oe(p0_oe), .p1_i({6'h3F, wait_n, irq_pin}), .p1_o(p1_o), .p1_oe(p1_oe),
    .p3_o(p3_o), .p3_oe(p3_oe), .ext_irq_zero(irq0), .port1_bit1_is_wait(is_wait)
  );
  emc_mem_model u_emc_mem_model (
    .pclk(pclk), .p0_o(p0_o), .p0_oe(p0_oe), .p1_o(p1_o), .p1_oe(p1_oe), .p3_o(p3_o),
    .stall_en(stall), .p0_i(p0_i), .wait_n(wait_n)
  );

  task automatic check(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input b);
    presetn <= 1'b0;
    boot <= b;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // apb transfer; reads compare the data and the error flag
  task automatic apb(input [11:0] a, input w, input [7:0] d, input [8:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w)
      check({23'h0, pslverr, prdata[7:0]}, {23'h0, x});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // core access; the expected {latency, ext, blocked, data} is queued
  task automatic acc(input w, input ce, input [15:0] a, input [7:0] d, input [15:0] x);
    @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_wr <= w;
    cpu_ce <= ce;
    cpu_addr <= a;
    cpu_wdata <= d;
    exp_q.push_back(x);
    do @(posedge pclk); while (cpu_ack !== 1'b1);
    cpu_req <= 1'b0;
  endtask

  // latency 3F stands for a stretched access longer than seven cycles
  always @(posedge pclk)
  begin
    lat <= cpu_req ? lat + 6'h01 : 6'h00;
    if (cpu_ack === 1'b1)
    begin
      e = exp_q.pop_front();
      check({16'h0, (e[15:10] == 6'h3F && lat > 6'h07) ? 6'h3F : lat, cpu_ext, cpu_blocked, cpu_rdata},
            {16'h0, e});
    end
  end
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard, far beyond the hundred or so cycles the run needs
  initial
  begin
    #40000;
    num_errors++;
    stop_test;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, cpu_req, cpu_wr, cpu_ce, stall, lat} = '0;
    {paddr, pwdata, cpu_addr, cpu_wdata} = '0;
    boot = 1'b1;
    irq_pin = 1'b1;
    rnd = $urandom(32'h5F33);
    gp0 = $urandom;
    gp1 = $urandom;
    gp3 = $urandom;
    rnd = $urandom;
    do_reset(1'b1);
    // strap high: single chip, all pins stay ports
    apb(12'h0CC, 1'b0, 8'h00, 9'h009);
    apb(12'h0C8, 1'b0, 8'h00, 9'h000);
    apb(12'h100, 1'b0, 8'h00, 9'h100);
    acc(1'b0, 1'b0, 16'h023F, 8'h00, 16'h0400);
    check({7'h0, irq0, p0_oe, p1_oe, p3_oe}, 32'h01000000);
    // enable the bus; later writes to the one-shot fields are dropped
    apb(12'h0C4, 1'b1, 8'hEC, 9'h000);
    apb(12'h0C4, 1'b1, 8'h00, 9'h000);
    apb(12'h0C8, 1'b1, 8'h4C, 9'h000);
    apb(12'h0C8, 1'b1, 8'h8D, 9'h000);
    apb(12'h0C8, 1'b0, 8'h00, 9'h00C);
    apb(12'h0CC, 1'b0, 8'h00, 9'h07A);
    acc(1'b1, 1'b1, {8'h40, rnd}, rnd ^ 8'h5A, 16'h1A00);
    acc(1'b0, 1'b1, {8'h40, rnd}, 8'h00, {8'h1A, rnd ^ 8'h5A});
    check({30'h0, is_wait, irq0}, 32'h0);
    acc(1'b0, 1'b1, 16'hFFBF, 8'h00, 16'h0500);
    acc(1'b0, 1'b1, 16'hFFC0, 8'h00, 16'h0400);
    acc(1'b0, 1'b0, 16'hC000, 8'h00, 16'h0400);
    // strap low: external code space, stretched waits from the wait pin
    do_reset(1'b0);
    apb(12'h0CC, 1'b0, 8'h00, 9'h0CB);
    apb(12'h0C8, 1'b1, 8'h8D, 9'h000);
    @(posedge pclk);
    check({31'h0, is_wait}, 32'h1);
    stall <= 1'b1;
    acc(1'b1, 1'b0, 16'hC123, rnd, 16'hFE00);
    acc(1'b0, 1'b0, 16'hC123, 8'h00, {8'hFE, rnd});
    repeat (4) @(posedge pclk);
    stop_test;
  end
endmodule // ext_memory_bus_control_tb

/* verilog/emc_consts.vh */
`ifndef EMC_CONSTS_VH
`define EMC_CONSTS_VH
// register indices, byte address is four times the index
`define EMC_EXP_IDX       8'h31
`define EMC_WAIT_IDX      8'h32
`define EMC_STAT_IDX      8'h33
// expansion_control fields
`define EMC_EXP_ABUS_HI   7
`define EMC_EXP_ABUS_LO   5
`define EMC_EXP_RD_BIT    3
`define EMC_EXP_WR_BIT    2
`define EMC_EXP_RST_LOW   8'hEC
`define EMC_EXP_RST_HIGH  8'h00
// wait_state_control fields
`define EMC_WT_MODE_HI    7
`define EMC_WT_MODE_LO    6
`define EMC_WT_CLK_HI     3
`define EMC_WT_CLK_LO     2
`define EMC_WT_ROM_BIT    0
`define EMC_WT_RST_LOW    8'h4D
`define EMC_WT_RST_HIGH   8'h01
// wait modes and bus clock modes
`define EMC_WAIT_FIXED    2'h1
`define EMC_WAIT_EXT      2'h2
`define EMC_CLK_IN_WAIT   2'h2
`define EMC_CLK_ALWAYS    2'h3
// address map
`define EMC_SFR_END       16'h003F
`define EMC_RAM_BASE      16'h0040
`define EMC_RAM_END       16'h023F
`define EMC_ROM_BASE      16'hC000
`define EMC_VEC_BASE      16'hFFC0
// read value of a blocked or unbacked access
`define EMC_BLOCK_DATA    8'h00
`endif

/* verilog/emc_ctrl.v */
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`include "emc_consts.vh"

module emc_ctrl #(
  parameter AW = 16,
  parameter DW = 8
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // strap, sampled once after reset release
  input  wire          boot_source_pin,
  // core memory request
  input  wire          cpu_req,
  input  wire          cpu_wr,
  input  wire          cpu_code_ext,
  input  wire [AW-1:0] cpu_addr,
  input  wire [DW-1:0] cpu_wdata,
  output reg           cpu_ack,
  output reg  [DW-1:0] cpu_rdata,
  output reg           cpu_ext,
  output reg           cpu_blocked,
  output reg  [2:0]    cpu_region,
  // general port logic that owns the pins when the bus does not
  input  wire [7:0]    gp_p0_o,
  input  wire [7:0]    gp_p0_oe,
  input  wire [7:0]    gp_p1_o,
  input  wire [7:0]    gp_p1_oe,
  input  wire [7:0]    gp_p3_o,
  input  wire [7:0]    gp_p3_oe,
  // pins: port0 is muxed_addr_data, port3 is upper_addr
  input  wire [7:0]    p0_i,
  output reg  [7:0]    p0_o,
  output reg  [7:0]    p0_oe,
  input  wire [7:0]    p1_i,
  output reg  [7:0]    p1_o,
  output reg  [7:0]    p1_oe,
  output reg  [7:0]    p3_o,
  output reg  [7:0]    p3_oe,
  // pin functions handed to other blocks
  output wire          ext_irq_zero,
  output wire          port1_bit1_is_wait
);

  // one-hot bus cycle states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ALE  = 6'h02;
  localparam [5:0] S_ADR  = 6'h04;
  localparam [5:0] S_STB  = 6'h08;
  localparam [5:0] S_WT   = 6'h10;
  localparam [5:0] S_END  = 6'h20;

  reg  [7:0]    exp_r;
  reg  [7:0]    wt_r;
  reg           exp_done_r;
  reg           wt_done_r;
  reg           strap_taken_r;
  reg           rom_less_r;
  reg  [5:0]    st_r;
  reg  [5:0]    st_nxt;
  reg  [AW-1:0] addr_r;
  reg  [DW-1:0] wdata_r;
  reg           wr_r;
  reg           bclk_r;

  wire [2:0] abus_en  = exp_r[`EMC_EXP_ABUS_HI:`EMC_EXP_ABUS_LO];
  wire       rd_en    = exp_r[`EMC_EXP_RD_BIT];
  wire       wr_en    = exp_r[`EMC_EXP_WR_BIT];
  wire [1:0] wt_mode  = wt_r[`EMC_WT_MODE_HI:`EMC_WT_MODE_LO];
  wire [1:0] clk_mode = wt_r[`EMC_WT_CLK_HI:`EMC_WT_CLK_LO];
  wire       rom_ok   = wt_r[`EMC_WT_ROM_BIT];
  wire       bus_on   = rd_en | wr_en;

  // apb decode; byte address is four times the register index
  wire       apb_wr   = psel & penable & pwrite;
  wire [7:0] idx      = paddr[9:2];
  wire       hit_exp  = (paddr[11:10] == 2'h0) && (idx == `EMC_EXP_IDX) && (paddr[1:0] == 2'h0);
  wire       hit_wt   = (paddr[11:10] == 2'h0) && (idx == `EMC_WAIT_IDX) && (paddr[1:0] == 2'h0);
  wire       hit_stat = (paddr[11:10] == 2'h0) && (idx == `EMC_STAT_IDX) && (paddr[1:0] == 2'h0);
  wire       unmapped = ~(hit_exp | hit_wt | hit_stat);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & unmapped;

  // control registers; reset constant, then strap value loaded on the first edge after release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exp_r         <= `EMC_EXP_RST_HIGH;
      wt_r          <= `EMC_WT_RST_HIGH;
      exp_done_r    <= 1'b0;
      wt_done_r     <= 1'b0;
      strap_taken_r <= 1'b0;
      rom_less_r    <= 1'b0;
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      rom_less_r    <= ~boot_source_pin;
      exp_r <= boot_source_pin ? `EMC_EXP_RST_HIGH : `EMC_EXP_RST_LOW;
      wt_r  <= boot_source_pin ? `EMC_WT_RST_HIGH : `EMC_WT_RST_LOW;
    end
    else
    begin
      if (apb_wr && hit_exp && !exp_done_r)
      begin
        // later writes are dropped so the bus setup cannot be disturbed
        exp_r      <= {pwdata[7:5], 1'b0, pwdata[3:2], 2'h0};
        exp_done_r <= 1'b1;
      end
      if (apb_wr && hit_wt)
      begin
        // bus clock mode stays rewritable
        wt_r[`EMC_WT_CLK_HI:`EMC_WT_CLK_LO] <= pwdata[3:2];
        if (!wt_done_r)
        begin
          wt_r[`EMC_WT_MODE_HI:`EMC_WT_MODE_LO] <= pwdata[7:6];
          wt_r[`EMC_WT_ROM_BIT]                 <= pwdata[0];
          wt_done_r                             <= 1'b1;
        end
      end
    end
  end

  // expansion control is write-only, wait control reads back only its clock mode; status word shows block state
  reg [31:0] rd_word;
  always @*
  begin
    rd_word = 32'h0;
    if (hit_wt)
      rd_word = {28'h0, clk_mode, 2'h0};
    else if (hit_stat)
    begin
      rd_word[7]   = rom_less_r;
      rd_word[6]   = bus_on;
      rd_word[5]   = wt_done_r;
      rd_word[4]   = exp_done_r;
      rd_word[3]   = st_r[0];
      rd_word[2:1] = wt_mode;
      rd_word[0]   = rom_ok;
    end
  end
  assign prdata = rd_word;

  // address decode of the core request
  wire is_sfr = (cpu_addr <= `EMC_SFR_END);
  wire is_ram = (cpu_addr >= `EMC_RAM_BASE) && (cpu_addr <= `EMC_RAM_END);
  wire is_rom = (cpu_addr >= `EMC_ROM_BASE) && !rom_less_r;
  wire is_vec = (cpu_addr >= `EMC_VEC_BASE);
  wire go_ext = !(is_sfr | is_ram | is_rom);
  // protected reads return a fixed value; vectors always pass
  wire blocked = is_rom && !cpu_wr && cpu_code_ext && !rom_ok && !is_vec;

  // extended wait only listens to the pin in mode 10
  wire wait_ext  = (wt_mode == `EMC_WAIT_EXT);
  wire any_wait  = (wt_mode == `EMC_WAIT_FIXED) || wait_ext;
  wire wait_hold = wait_ext && !p1_i[1];

  // the request is still up in the cycle after an ack; taking it then would run it twice
  wire take     = st_r[0] && cpu_req && !cpu_ack;
  wire take_ext = take && go_ext && bus_on;

  // bus cycle sequencer
  always @*
  begin
    st_nxt = S_IDLE;
    case (st_r)
      S_IDLE :
        if (take_ext)
          st_nxt = S_ALE;
        else
          st_nxt = S_IDLE;
      S_ALE :
        st_nxt = S_ADR;
      S_ADR :
        st_nxt = S_STB;
      S_STB :
        if (any_wait)
          st_nxt = S_WT;
        else
          st_nxt = S_END;
      S_WT :
        if (wait_hold)
          st_nxt = S_WT;
        else
          st_nxt = S_END;
      S_END :
        st_nxt = S_IDLE;
      default :
        st_nxt = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r        <= S_IDLE;
      addr_r      <= {AW{1'b0}};
      wdata_r     <= {DW{1'b0}};
      wr_r        <= 1'b0;
      cpu_ack     <= 1'b0;
      cpu_rdata   <= {DW{1'b0}};
      cpu_ext     <= 1'b0;
      cpu_blocked <= 1'b0;
      cpu_region  <= 3'h0;
    end
    else
    begin
      st_r        <= st_nxt;
      cpu_ack     <= 1'b0;
      cpu_blocked <= 1'b0;
      if (take)
      begin
        cpu_ext    <= go_ext;
        cpu_region <= {is_rom, is_ram, is_sfr};
        if (go_ext && bus_on)
        begin
          // hold request for the whole external cycle
          addr_r  <= cpu_addr;
          wdata_r <= cpu_wdata;
          wr_r    <= cpu_wr;
        end
        else
        begin
          // internal or unbacked access answers next cycle
          cpu_ack     <= 1'b1;
          cpu_blocked <= blocked;
          cpu_rdata   <= `EMC_BLOCK_DATA;
        end
      end
      if (st_r == S_END)
      begin
        cpu_ack   <= 1'b1;
        cpu_rdata <= wr_r ? `EMC_BLOCK_DATA : p0_i;
      end
    end
  end

  // bus clock: high, toggling only in waits, or toggling always
  // mode 10 is silent outside waits, so a memory that needs a free clock must use mode 11
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bclk_r <= 1'b1;
    else if (clk_mode == `EMC_CLK_ALWAYS)
      bclk_r <= ~bclk_r;
    else if (clk_mode == `EMC_CLK_IN_WAIT && st_r == S_WT)
      bclk_r <= ~bclk_r;
    else
      bclk_r <= 1'b1;
  end

  // pin mux, registered so pins follow the sequencer by one clock
  reg [7:0] p0_o_nxt;
  reg [7:0] p0_oe_nxt;
  reg [7:0] p1_o_nxt;
  reg [7:0] p1_oe_nxt;
  wire [7:0] p3_o_nxt;
  wire [7:0] p3_oe_nxt;
  wire       drive_adr = (st_r == S_ALE) || (st_r == S_ADR);
  wire       drive_dat = wr_r && ((st_r == S_STB) || (st_r == S_WT) || (st_r == S_END));
  wire       strobe    = (st_r == S_STB) || (st_r == S_WT);

  always @*
  begin
    p0_o_nxt  = gp_p0_o;
    p0_oe_nxt = gp_p0_oe;
    p1_o_nxt  = gp_p1_o;
    p1_oe_nxt = gp_p1_oe;
    if (bus_on)
    begin
      // low address, then data, then released for reads
      p0_o_nxt  = drive_adr ? addr_r[7:0] : wdata_r;
      p0_oe_nxt = (drive_adr || drive_dat) ? 8'hFF : 8'h00;
      p1_o_nxt[7]  = (st_r == S_ALE);
      p1_oe_nxt[7] = 1'b1;
      p1_o_nxt[0]  = bclk_r;
      p1_oe_nxt[0] = 1'b1;
    end
    if (rd_en)
    begin
      p1_o_nxt[6]  = ~(strobe && !wr_r);
      p1_oe_nxt[6] = 1'b1;
    end
    if (wr_en)
    begin
      p1_o_nxt[5]  = ~(strobe && wr_r);
      p1_oe_nxt[5] = 1'b1;
    end
    if (wait_ext)
    begin
      p1_o_nxt[1]  = 1'b0;
      p1_oe_nxt[1] = 1'b0;
    end
  end

  // upper address pins: a nonzero field n drives A8 up to A8+n
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1)
    begin : g_upper
      wire on = (abus_en != 3'h0) && (k <= abus_en);
      assign p3_o_nxt[k]  = on ? addr_r[8+k] : gp_p3_o[k];
      assign p3_oe_nxt[k] = on ? 1'b1 : gp_p3_oe[k];
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p0_o  <= 8'h00;
      p0_oe <= 8'h00;
      p1_o  <= 8'h00;
      p1_oe <= 8'h00;
      p3_o  <= 8'h00;
      p3_oe <= 8'h00;
    end
    else
    begin
      p0_o  <= p0_o_nxt;
      p0_oe <= p0_oe_nxt;
      p1_o  <= p1_o_nxt;
      p1_oe <= p1_oe_nxt;
      p3_o  <= p3_o_nxt;
      p3_oe <= p3_oe_nxt;
    end
  end

  // interrupt 0 input is cut off while the pin carries the bus clock
  assign ext_irq_zero       = p1_i[0] & ~bus_on;
  assign port1_bit1_is_wait = wait_ext;

endmodule // emc_ctrl
